// *** hw/srm_top.sv ***
// system reset sequencing, supply and temperature monitoring, pin interrupts
`timescale 1ns/10ps
module srm_top (
  // clock, reset, enable
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic                          clk_en,
  // asynchronous analog and pin inputs
  input  wire srm_pkg::srm_sense_type        sense_in,
  input  wire logic [srm_pkg::NUM_PINS-1:0]  pin_in,
  // reset requests, same clock domain
  input  wire srm_pkg::srm_req_type          req_in,
  input  wire logic                          bus_rst_en,
  // configuration bits
  input  wire logic                          reg_lvl_sel,
  input  wire logic                          bod_lvl_sel,
  input  wire logic                          hpd_lvl_sel,
  input  wire logic                          auto_hpd_en,
  input  wire logic [1:0]                    trip_sel_tx,
  input  wire logic [1:0]                    trip_sel_card,
  input  wire logic                          bod_irq_en,
  input  wire logic                          temp_irq_en,
  input  wire logic [srm_pkg::NUM_PINS-1:0]  pin_irq_en,
  input  wire logic [srm_pkg::NUM_PINS-1:0]  pin_edge_mode,
  input  wire logic                          standby_req,
  input  wire logic                          dbg_off_nv,
  // flag clears, one pulse per bit
  input  wire logic [1:0]                    temp_clr,
  input  wire logic                          bod_clr,
  input  wire logic [srm_pkg::NUM_PINS-1:0]  pin_clr,
  // status
  output logic                               reg_above_sel,
  output logic                               bod_below,
  output logic [1:0]                         temp_flag,
  output logic                               bod_flag,
  output logic [srm_pkg::NUM_PINS-1:0]       pin_flag,
  output logic                               cpu_irq,
  output logic                               hard_power_down,
  output logic                               standby,
  output logic                               wake,
  // reset outputs, active high
  output logic                               rst_core,
  output logic                               rst_unit,
  output logic                               rst_debug,
  output logic [31:0]                        boot_addr,
  output logic                               dbg_port_en,
  // trip code per detector toward the analog sensors
  output logic [1:0]                         trip_tx,
  output logic [1:0]                         trip_card
);

  // two-stage synchronisers for everything from outside the clock
  localparam int unsigned SW = $bits(srm_pkg::srm_sense_type) + srm_pkg::NUM_PINS;
  logic [SW-1:0]          sync1_q;           // first stage, read only by second
  logic [SW-1:0]          sync2_q;           // second stage, safe to use
  srm_pkg::srm_sense_type sn;                // synchronised sense bits
  logic [srm_pkg::NUM_PINS-1:0] pin_s;       // synchronised pins
  logic [1:0]             trip_tx_q;         // trip code registers
  logic [1:0]             trip_card_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= {sense_in, pin_in};
      sync2_q <= sync1_q;
    end
  end

  assign sn    = srm_pkg::srm_sense_type'(sync2_q[SW-1:srm_pkg::NUM_PINS]);
  assign pin_s = sync2_q[srm_pkg::NUM_PINS-1:0];

  srm_pkg::srm_regs_type r_q; // registered state
  srm_pkg::srm_regs_type r_d; // next state

  // per-pin event detection, edge or level
  logic [srm_pkg::NUM_PINS-1:0] pin_evt;
  genvar gi;
  generate
    for (gi = 0; gi < srm_pkg::NUM_PINS; gi++) begin : g_pin
      // edge mode sees a rising edge only, level mode sees a high level
      assign pin_evt[gi] = pin_irq_en[gi] &
        (pin_edge_mode[gi] ? (pin_s[gi] & ~r_q.pin_prev[gi]) : pin_s[gi]);
    end
  endgenerate

  // combinational helpers
  logic bod_now;    // main supply below chosen brown-out level
  logic hpd_now;    // main supply below chosen power-down level
  logic any_req;    // qualified warm reset request

  always_comb begin
    bod_now = (bod_lvl_sel == srm_pkg::LVL_LOW) ? ~sn.main_above_23
                                                : ~sn.main_above_27;
    hpd_now = auto_hpd_en & ((hpd_lvl_sel == srm_pkg::LVL_LOW) ? ~sn.main_above_23
                                                               : ~sn.main_above_27);
    any_req = req_in.unit_soft | req_in.cpu_soft | req_in.watchdog
            | (req_in.bus_cmd & bus_rst_en);
  end

  // next-state logic for the block, apart from synchronisers and trip codes
  always_comb begin
    r_d = r_q;
    r_d.pin_prev = pin_s;
    // sticky flags: a set in the clear cycle wins
    r_d.temp_flag = (r_q.temp_flag & ~temp_clr) | sn.temp_over;
    r_d.bod_flag  = (r_q.bod_flag & ~bod_clr) | bod_now;
    r_d.pin_flag  = (r_q.pin_flag & ~pin_clr) | pin_evt;
    // one-way debug lock, only a power-on reset could clear it
    r_d.dbg_off   = r_q.dbg_off | dbg_off_nv;
    r_d.pad_ok    = reg_lvl_sel ? sn.reg_above_40 : sn.reg_above_27;
    r_d.bod_lvl   = bod_now;
    r_d.wake      = 1'b0;
    // standby entered by firmware; left when both detectors cool down
    if (standby_req) begin
      r_d.standby = 1'b1;
    end else if (r_q.standby && (sn.temp_over == 2'b00)) begin
      r_d.standby = 1'b0;
      r_d.wake    = 1'b1;
    end
    case (r_q.st)
      srm_pkg::SRM_ST_POR: begin
        // whole chip held until main supply is good and the reset pin is high
        r_d.por_rst  = 1'b1;
        r_d.warm_rst = 1'b1;
        r_d.dbg_off  = dbg_off_nv;
        if (sn.main_above_23 && sn.rst_pin) begin
          r_d.st      = srm_pkg::SRM_ST_RUN;
          r_d.por_rst = 1'b0;
          r_d.warm_rst = 1'b0;
        end
      end
      srm_pkg::SRM_ST_RUN: begin
        if (!sn.rst_pin || hpd_now) begin
          r_d.st       = srm_pkg::SRM_ST_HPD;
          r_d.warm_rst = 1'b1;
        end else if (any_req) begin
          r_d.st       = srm_pkg::SRM_ST_WARM;
          r_d.warm_rst = 1'b1;
          r_d.cnt      = '0;
        end
      end
      srm_pkg::SRM_ST_WARM: begin
        // warm reset: core only, unit and debug keep their state
        r_d.cnt = r_q.cnt + 5'h01;
        if (r_q.cnt == srm_pkg::WARM_CNT_W - 5'h01) begin
          r_d.st       = srm_pkg::SRM_ST_RUN;
          r_d.warm_rst = 1'b0;
        end
      end
      srm_pkg::SRM_ST_HPD: begin
        // leave only with pin high and supply above 2.3 V together
        r_d.warm_rst = 1'b1;
        r_d.standby  = 1'b0;
        if (sn.rst_pin && sn.main_above_23) begin
          r_d.st = srm_pkg::SRM_ST_POR;
          r_d.por_rst = 1'b1;
        end
      end
      default: begin
        r_d.st = srm_pkg::SRM_ST_POR;
      end
    endcase
  end

  // state register; rst_b is the power-on reset of this unit
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      r_q          <= '0;
      r_q.st       <= srm_pkg::SRM_ST_POR;
      r_q.por_rst  <= 1'b1;
      r_q.warm_rst <= 1'b1;
      trip_tx_q    <= srm_pkg::TRIP_RST;
      trip_card_q  <= srm_pkg::TRIP_RST;
    end else if (clk_en) begin
      r_q <= r_d;
      // trip codes are control-unit state, spared by warm resets
      trip_tx_q   <= trip_sel_tx;
      trip_card_q <= trip_sel_card;
    end
  end

  // outputs, from flip-flops; cpu_irq, rst_core, hard_power_down and dbg_port_en through gates, boot_addr a constant
  assign reg_above_sel   = r_q.pad_ok;
  assign bod_below       = r_q.bod_lvl;
  assign temp_flag       = r_q.temp_flag;
  assign bod_flag        = r_q.bod_flag;
  assign pin_flag        = r_q.pin_flag;
  assign cpu_irq         = (r_q.bod_flag & bod_irq_en)
                         | ((|r_q.temp_flag) & temp_irq_en)
                         | (|r_q.pin_flag);
  assign hard_power_down = (r_q.st == srm_pkg::SRM_ST_HPD);
  assign standby         = r_q.standby;
  assign wake            = r_q.wake;
  assign rst_core        = r_q.warm_rst | r_q.por_rst;
  assign rst_unit        = r_q.por_rst;
  assign rst_debug       = r_q.por_rst;
  assign boot_addr       = srm_pkg::BOOT_VECTOR;
  assign dbg_port_en     = ~r_q.dbg_off & ~r_q.por_rst;
  assign trip_tx         = trip_tx_q;
  assign trip_card       = trip_card_q;

endmodule : srm_top

// *** hw/srm_pkg.sv ***
// package of constants and carriers for the system reset and supply monitor
package srm_pkg;

  localparam int unsigned NUM_PINS      = 12;          // external interrupt pins
  localparam logic [1:0]  TRIP_RST      = 2'h3;        // 120 degree setting after reset
  localparam logic [1:0]  TRIP_135      = 2'h0;        // trip code for 135 degrees
  localparam logic [31:0] BOOT_VECTOR   = 32'h00000000; // first fetch address
  localparam logic        LVL_LOW       = 1'b0;        // level select: lower threshold
  localparam int unsigned WARM_PULSE    = 16;          // cycles a warm reset is held
  localparam logic [4:0]  WARM_CNT_W    = 5'h10;       // warm pulse count at width

  // reset sequencer states, gray along the usual path
  typedef enum logic [1:0] {
    SRM_ST_POR  = 2'b00,
    SRM_ST_RUN  = 2'b01,
    SRM_ST_WARM = 2'b11,
    SRM_ST_HPD  = 2'b10
  } srm_state_type;

  // analog comparator results and reset pin level after synchronising
  typedef struct packed {
    logic       main_above_23;   // main supply above 2.3 V
    logic       main_above_27;   // main supply above 2.7 V
    logic       reg_above_27;    // regulator input above 2.7 V
    logic       reg_above_40;    // regulator input above 4.0 V
    logic [1:0] temp_over;       // per detector above its trip
    logic       rst_pin;         // external reset pin level
  } srm_sense_type;

  // reset request sources
  typedef struct packed {
    logic unit_soft;   // control unit soft reset
    logic cpu_soft;    // processor software reset
    logic bus_cmd;     // bus reset command
    logic watchdog;    // watchdog expiry
  } srm_req_type;

  // state of the block, apart from the synchronisers and trip code registers
  typedef struct packed {
    srm_state_type        st;
    logic [4:0]           cnt;
    logic [1:0]           temp_flag;
    logic                 bod_flag;
    logic [NUM_PINS-1:0]  pin_flag;
    logic [NUM_PINS-1:0]  pin_prev;
    logic                 dbg_off;
    logic                 warm_rst;
    logic                 por_rst;
    logic                 wake;
    logic                 standby;
    logic                 pad_ok;
    logic                 bod_lvl;
  } srm_regs_type;

endpackage : srm_pkg

// *** sim/srm_props.sv ***
// port checker for the reset and supply monitor
`timescale 1ns/10ps
module srm_props (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  input wire logic                   clk_en,
  // watched inputs
  input wire srm_pkg::srm_sense_type sense_in,
  input wire srm_pkg::srm_req_type   req_in,
  input wire logic                   bod_irq_en,
  input wire logic                   temp_irq_en,
  input wire logic                   bod_clr,
  input wire logic                   dbg_off_nv,
  // watched outputs
  input wire logic                   bod_flag,
  input wire logic [1:0]             temp_flag,
  input wire logic [11:0]            pin_flag,
  input wire logic                   cpu_irq,
  input wire logic                   hard_power_down,
  input wire logic                   standby,
  input wire logic                   rst_core,
  input wire logic                   rst_unit,
  input wire logic                   rst_debug,
  input wire logic [31:0]            boot_addr,
  input wire logic                   dbg_port_en,
  input wire logic [1:0]             trip_tx,
  input wire logic [1:0]             trip_card
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // half of a warm pulse; two of them make the sixteen cycles
  sequence core_high8;
    rst_core [*8];
  endsequence
  a_boot_vector: assert property (boot_addr == 32'h0)
    else $error("boot address not zero");
  a_trip_default: assert property ($rose(rst_b) |-> trip_tx == 2'h3 && trip_card == 2'h3)
    else $error("trip code not 120 after reset");
  // run state seen as no reset, no power-down, no standby
  a_warm_scope: assert property ((req_in.watchdog || req_in.cpu_soft || req_in.unit_soft)
    && !rst_core && !hard_power_down && !standby && clk_en |=> rst_core && !rst_unit)
    else $error("warm request did not reset core alone");
  a_warm_length: assert property ($rose(rst_core) && !rst_unit && !hard_power_down
    |-> core_high8 ##1 core_high8 ##1 !rst_core)
    else $error("warm pulse not sixteen cycles");
  a_debug_with_unit: assert property (rst_debug == rst_unit)
    else $error("debug reset apart from unit reset");
  // unit reset or power-down may legally wipe the flag
  a_bod_sticky: assert property (bod_flag && !bod_clr && !rst_unit && !hard_power_down
    |=> bod_flag || rst_unit || hard_power_down)
    else $error("brown-out flag lost without clear");
  a_bod_irq: assert property (bod_flag && bod_irq_en |-> cpu_irq)
    else $error("enabled brown-out gave no interrupt");
  // pin flags feed the interrupt ungated, so the quiet case needs them clear
  a_irq_quiet: assert property (!bod_irq_en && !temp_irq_en && pin_flag == 12'h000 |-> !cpu_irq)
    else $error("interrupt with all sources off");
  a_temp_irq: assert property (temp_flag != 2'h0 && temp_irq_en |-> cpu_irq)
    else $error("over-temperature gave no interrupt");
  // the pin level reaches the core two flops late
  a_hpd_hold: assert property (hard_power_down && !sense_in.rst_pin
    && !$past(sense_in.rst_pin) && !$past(sense_in.rst_pin, 2) |=> hard_power_down)
    else $error("power-down left with reset pin low");
  a_debug_lock: assert property (dbg_off_nv && $past(dbg_off_nv) && !rst_unit
    |=> !dbg_port_en)
    else $error("debug port enabled while locked");
endmodule : srm_props
bind srm_top srm_props srm_props_inst (.*);

// *** sim/srm_top_test.sv ***
// self-checking bench for the reset and supply monitor
`timescale 1ns/10ps
module srm_top_test;
  // clock, reset and inputs, all valued at time zero
  logic clk_sys = 1'h0, rst_b = 1'h0, clk_en = 1'h1;
  srm_pkg::srm_sense_type sense_in = '0;
  srm_pkg::srm_req_type req_in = '0;
  logic [11:0] pin_in = '0, pin_irq_en = '0, pin_edge_mode = '0, pin_clr = '0, pin_flag;
  logic bus_rst_en = 0, reg_lvl_sel = 0, bod_lvl_sel = 0, hpd_lvl_sel = 0, auto_hpd_en = 0;
  logic [1:0] trip_sel_tx = 2'h3, trip_sel_card = 2'h3, temp_clr = 2'h0;
  logic bod_irq_en = 0, temp_irq_en = 0, standby_req = 0, dbg_off_nv = 0, bod_clr = 0;
  // outputs
  logic reg_above_sel, bod_below, bod_flag, cpu_irq, hard_power_down, standby, wake;
  logic rst_core, rst_unit, rst_debug, dbg_port_en;
  logic [1:0] temp_flag, trip_tx, trip_card;
  logic [31:0] boot_addr;
  int n_fail = 0, cmp_count = 0;
  srm_top srm_top_inst (.*);
  always #2.5 clk_sys = ~clk_sys;
  // inputs change on the falling edge only
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("mismatches %0d, compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // release waits for the main supply above 2.3 V and the reset pin high
  task automatic t_power_on;
    cyc(8); rst_b = 1'h1; cyc(6);
    chk("rst_core", 1, rst_core);
    sense_in.main_above_23 = 1; sense_in.main_above_27 = 1; sense_in.rst_pin = 1; cyc(6);
    chk("rst_core", 0, rst_core);
    chk("rst_unit", 0, rst_unit);
    chk("boot_addr", 0, boot_addr);
    chk("trip_tx", 3, trip_tx);
    for (int i = 0; i < 4; i++) begin
      trip_sel_tx = i; trip_sel_card = 3 - i; cyc(2);
      chk("trip_tx", i, trip_tx);
      chk("trip_card", 3 - i, trip_card);
    end
  endtask : t_power_on
  // both regulator input levels
  task automatic t_reg_monitor;
    sense_in.reg_above_27 = 1; cyc(5);
    chk("reg_above_sel", 1, reg_above_sel);
    reg_lvl_sel = 1; cyc(5);
    chk("reg_above_sel", 0, reg_above_sel);
    sense_in.reg_above_40 = 1; cyc(5);
    chk("reg_above_sel", 1, reg_above_sel);
  endtask : t_reg_monitor
  // every source; bus command once refused, once taken
  task automatic t_warm;
    for (int k = 0; k < 5; k++) begin
      bus_rst_en = (k == 4);
      req_in = srm_pkg::srm_req_type'(4'h1 << ((k == 4) ? 1 : k)); cyc(1);
      req_in = '0; cyc(1);
      chk("rst_core", k != 1, rst_core);
      chk("rst_unit", 0, rst_unit);
      cyc(20);
      chk("rst_core", 0, rst_core);
    end
  endtask : t_warm
  // brown-out at 2.7 V, polled, sticky, then enabled and cleared
  task automatic t_brownout;
    bod_lvl_sel = 1; sense_in.main_above_27 = 0; cyc(6);
    chk("bod_below", 1, bod_below);
    chk("bod_flag", 1, bod_flag);
    chk("cpu_irq", 0, cpu_irq);
    bod_lvl_sel = 0; cyc(3);
    chk("bod_below", 0, bod_below);
    sense_in.main_above_27 = 1; bod_irq_en = 1; cyc(4);
    chk("bod_flag", 1, bod_flag);
    chk("cpu_irq", 1, cpu_irq);
    bod_clr = 1; cyc(1); bod_clr = 0; bod_irq_en = 0; cyc(2);
    chk("bod_flag", 0, bod_flag);
  endtask : t_brownout
  // card detector trips, standby, then cooling wakes
  task automatic t_thermal;
    logic seen;
    seen = 0;
    temp_irq_en = 1; sense_in.temp_over = 2'h2; cyc(6);
    chk("temp_flag", 2, temp_flag);
    chk("cpu_irq", 1, cpu_irq);
    standby_req = 1; cyc(1); standby_req = 0; cyc(1);
    chk("standby", 1, standby);
    sense_in.temp_over = 2'h0;
    repeat (8) begin cyc(1); seen |= wake; end
    chk("wake", 1, seen);
    chk("standby", 0, standby);
    chk("temp_flag", 2, temp_flag);
    temp_clr = 2'h3; cyc(1); temp_clr = 2'h0; temp_irq_en = 0; cyc(2);
    chk("temp_flag", 0, temp_flag);
  endtask : t_thermal
  // pin 0 edge, pin 1 level, pin 11 not enabled
  task automatic t_pins;
    pin_irq_en = 12'h003; pin_edge_mode = 12'h001; pin_in = 12'h803; cyc(1);
    pin_in = '0; cyc(5);
    chk("pin_flag", 12'h003, pin_flag);
    pin_clr = 12'h003; cyc(1); pin_clr = '0; cyc(2);
    chk("pin_flag", 0, pin_flag);
  endtask : t_pins
  // lock, then pin power-down, exit only with supply back
  task automatic t_lock_hpd;
    logic seen;
    seen = 0;
    chk("dbg_port_en", 1, dbg_port_en);
    dbg_off_nv = 1; cyc(3); dbg_off_nv = 0; cyc(3);
    chk("dbg_port_en", 0, dbg_port_en);
    dbg_off_nv = 1; sense_in.rst_pin = 0; cyc(6);
    chk("hard_power_down", 1, hard_power_down);
    sense_in.main_above_23 = 0; sense_in.rst_pin = 1; cyc(8);
    chk("hard_power_down", 1, hard_power_down);
    sense_in.main_above_23 = 1;
    repeat (10) begin cyc(1); seen |= rst_unit; end
    chk("rst_unit", 1, seen);
    chk("hard_power_down", 0, hard_power_down);
    auto_hpd_en = 1; hpd_lvl_sel = 1; sense_in.main_above_27 = 0; cyc(6);
    chk("hard_power_down", 1, hard_power_down);
  endtask : t_lock_hpd
  // main sequence
  initial begin
    t_power_on(); t_reg_monitor(); t_warm(); t_brownout();
    t_thermal(); t_pins(); t_lock_hpd();
    end_of_test();
  end
  // watchdog well past the expected run
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule : srm_top_test
